// [pkg/isq_pkg.sv]
// What this block does
// [R01] host keeps both bus lines high at power-up
// [R02] no transfer before 15 ms after power-up
// [R03] host idles bus before pulling reset low
// [R04] host holds reset low at least minimum
// [R05] host raises reset before maximum low time
// [R06] reset low 10 us min, 2500 us max
// [R07] no transfer before 15 ms after reset rise
// [R08] pending store write stretches wait to 20 ms
// [R09] serial clock never faster than 1 MHz
// [R10] device stays off bus until startup ends
package isq_pkg;
   // ****************************************************
   // clock periods and documented times
   // ****************************************************
   localparam int HOST_CLK_PERIOD_NS = 100;
   localparam int DEV_CLK_PERIOD_NS = 6;
   localparam int NS_PER_MS = 1000000;
   localparam int NS_PER_US = 1000;
   localparam int STARTUP_MS = 15;
   localparam int STARTUP_NVM_MS = 20;
   localparam int RESET_LOW_MIN_US = 10;
   localparam int RESET_LOW_MAX_US = 2500;
   localparam int SCL_FMAX_KHZ = 1000;
   localparam int SCL_HALF_NS = NS_PER_MS / (2 * SCL_FMAX_KHZ);

   // ****************************************************
   // host cycle counts
   // ****************************************************
   localparam int HOST_STARTUP_CYC =
      (STARTUP_MS * NS_PER_MS + HOST_CLK_PERIOD_NS - 1) / HOST_CLK_PERIOD_NS;
   localparam int HOST_STARTUP_NVM_CYC =
      (STARTUP_NVM_MS * NS_PER_MS + HOST_CLK_PERIOD_NS - 1) / HOST_CLK_PERIOD_NS;
   localparam int HOST_RST_LOW_MIN_CYC =
      (RESET_LOW_MIN_US * NS_PER_US + HOST_CLK_PERIOD_NS - 1) / HOST_CLK_PERIOD_NS;
   localparam int HOST_RST_LOW_MAX_CYC =
      (RESET_LOW_MAX_US * NS_PER_US) / HOST_CLK_PERIOD_NS;
   localparam int HOST_SCL_HALF_CYC =
      (SCL_HALF_NS + HOST_CLK_PERIOD_NS - 1) / HOST_CLK_PERIOD_NS;
   localparam int HOST_SDA_DELAY_CYC = 1;
   localparam int HOST_CNT_W = 18;

   // ****************************************************
   // device cycle counts
   // ****************************************************
   localparam int DEV_STARTUP_CYC = (STARTUP_MS * NS_PER_MS) / DEV_CLK_PERIOD_NS;
   localparam int DEV_STARTUP_NVM_CYC = (STARTUP_NVM_MS * NS_PER_MS) / DEV_CLK_PERIOD_NS;
   localparam int DEV_CNT_W = 22;

   // ****************************************************
   // byte framing
   // ****************************************************
   localparam int BYTE_W = 8;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_FIRST = 4'h0;
endpackage

// [pkg/isq_link_if.sv]
`timescale 1ns/100ps
interface isq_link_if;
   // ****************************************************
   // pin drivers and resolved open-drain lines
   // ****************************************************
   logic rst_n;
   logic host_scl_o;
   logic host_scl_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic scl;
   logic sda;

   // pull-ups win unless an enabled driver pulls low
   assign scl = (!host_scl_oe_n && !host_scl_o) ? 1'b0 : 1'b1;
   assign sda = ((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o)) ?
                1'b0 : 1'b1;

   modport host (
      output rst_n, host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n,
      input scl, sda
   );
   modport dev (
      output dev_sda_o, dev_sda_oe_n,
      input rst_n, scl, sda
   );
endinterface

// [src/isq_dev.sv]
`timescale 1ns/100ps
module isq_dev #(
   parameter int STARTUP_CYC = isq_pkg::DEV_STARTUP_CYC,
   parameter int STARTUP_NVM_CYC = isq_pkg::DEV_STARTUP_NVM_CYC
) (
   // link clock
   input wire logic link_clk,
   // bus pins
   isq_link_if.dev bus,
   // user side
   input wire logic nvm_req,
   output logic ready,
   output logic [isq_pkg::BYTE_W-1:0] rx_byte,
   output logic rx_valid
);
   import isq_pkg::*;

   typedef enum logic [2:0] {D_RESET, D_STARTUP, D_IDLE, D_SHIFT, D_ACK} isq_dst_e;

   // ****************************************************
   // pin synchronisers
   // ****************************************************
   logic rst_meta, rst_sync, scl_meta, scl_sync, sda_meta, sda_sync;
   logic scl_d, sda_d;

   always_ff @(posedge link_clk) begin
      rst_meta <= bus.rst_n;
      rst_sync <= rst_meta;
      scl_meta <= bus.scl;
      scl_sync <= scl_meta;
      sda_meta <= bus.sda;
      sda_sync <= sda_meta;
      scl_d <= scl_sync;
      sda_d <= sda_sync;
   end

   logic in_rst, scl_rise, scl_fall, start_c, stop_c;
   assign in_rst = !rst_sync;
   assign scl_rise = scl_sync && !scl_d;
   assign scl_fall = !scl_sync && scl_d;
   assign start_c = scl_sync && scl_d && sda_d && !sda_sync;
   assign stop_c = scl_sync && scl_d && !sda_d && sda_sync;

   // ****************************************************
   // startup and receive sequencer
   // ****************************************************
   isq_dst_e st_r, st_nxt;
   logic [DEV_CNT_W-1:0] cnt_r, cnt_nxt, lim;
   logic nvm_r, nvm_nxt, drive_r, drive_nxt, rx_valid_r, rx_valid_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [BYTE_W-1:0] shf_r, shf_nxt, rx_byte_r, rx_byte_nxt;

   assign lim = nvm_r ? DEV_CNT_W'(STARTUP_NVM_CYC - 1) :
                DEV_CNT_W'(STARTUP_CYC - 1); // see [R08]

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      nvm_nxt = nvm_r;
      drive_nxt = drive_r;
      bit_nxt = bit_r;
      shf_nxt = shf_r;
      rx_byte_nxt = rx_byte_r;
      rx_valid_nxt = 1'b0;
      if (in_rst) begin
         // pin low resets after the two-flop synchroniser, so any valid low is detected
         st_nxt = D_RESET; // see [R06]
         cnt_nxt = '0;
         nvm_nxt = nvm_req;
         drive_nxt = 1'b0;
      end else begin
         case (st_r)
            D_RESET: begin
               st_nxt = D_STARTUP;
            end
            D_STARTUP: begin
               // bus ignored, line never driven
               if (cnt_r == lim) begin // see [R02] [R07] [R10]
                  st_nxt = D_IDLE;
               end else begin
                  cnt_nxt = cnt_r + 1'b1;
               end
            end
            D_IDLE: begin
               if (start_c) begin
                  st_nxt = D_SHIFT;
                  bit_nxt = BIT_FIRST;
               end
            end
            D_SHIFT: begin
               if (stop_c) begin
                  st_nxt = D_IDLE;
               end else if (start_c) begin
                  bit_nxt = BIT_FIRST;
               end else if (scl_rise && bit_r != BIT_ACK) begin
                  shf_nxt = {shf_r[BYTE_W-2:0], sda_sync};
                  bit_nxt = bit_r + 1'b1;
                  if (bit_r == BIT_LAST) begin
                     rx_byte_nxt = {shf_r[BYTE_W-2:0], sda_sync};
                     rx_valid_nxt = 1'b1;
                  end
               end else if (scl_fall && bit_r == BIT_ACK) begin
                  drive_nxt = 1'b1;
                  st_nxt = D_ACK;
               end
            end
            D_ACK: begin
               if (stop_c) begin
                  drive_nxt = 1'b0;
                  st_nxt = D_IDLE;
               end else if (scl_fall) begin
                  drive_nxt = 1'b0;
                  bit_nxt = BIT_FIRST;
                  st_nxt = D_SHIFT;
               end
            end
            default: begin
               st_nxt = D_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      nvm_r <= nvm_nxt;
      drive_r <= drive_nxt;
      bit_r <= bit_nxt;
      shf_r <= shf_nxt;
      rx_byte_r <= rx_byte_nxt;
      rx_valid_r <= rx_valid_nxt;
   end

   // ****************************************************
   // outputs
   // ****************************************************
   assign bus.dev_sda_o = 1'b0;
   assign bus.dev_sda_oe_n = !drive_r;
   assign ready = (st_r == D_IDLE) || (st_r == D_SHIFT) || (st_r == D_ACK);
   assign rx_byte = rx_byte_r;
   assign rx_valid = rx_valid_r;
endmodule

// [src/isq_host.sv]
`timescale 1ns/100ps
module isq_host #(
   parameter int STARTUP_CYC = isq_pkg::HOST_STARTUP_CYC,
   parameter int STARTUP_NVM_CYC = isq_pkg::HOST_STARTUP_NVM_CYC,
   parameter int RST_LOW_MAX_CYC = isq_pkg::HOST_RST_LOW_MAX_CYC,
   parameter int RST_HOLD_CYC = isq_pkg::HOST_RST_LOW_MIN_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // bus pins
   isq_link_if.host bus,
   // reset control
   input wire logic warm_rst_req,
   input wire logic nvm_pending,
   // transfer request
   input wire logic xfer_req,
   input wire logic [isq_pkg::BYTE_W-1:0] xfer_byte,
   // status
   output logic ready,
   output logic done,
   output logic ack_seen
);
   import isq_pkg::*;

   typedef enum logic [3:0] {
      H_RST_LOW, H_WAIT, H_IDLE, H_START, H_BIT_LOW, H_BIT_HIGH,
      H_STOP_LOW, H_STOP_HIGH, H_FREE
   } isq_hst_e;

   // ****************************************************
   // count helpers
   // ****************************************************
   // last count value of a span of n cycles
   function automatic logic [HOST_CNT_W-1:0] last_of(input int n);
      last_of = HOST_CNT_W'(n - 1);
   endfunction

   // hold time kept inside the legal low window
   function automatic int clamp_hold(input int v);
      if (v < HOST_RST_LOW_MIN_CYC) begin
         clamp_hold = HOST_RST_LOW_MIN_CYC;
      end else if (v > RST_LOW_MAX_CYC) begin
         clamp_hold = RST_LOW_MAX_CYC;
      end else begin
         clamp_hold = v;
      end
   endfunction

   localparam int HOLD_CYC = clamp_hold(RST_HOLD_CYC);

   // ****************************************************
   // line synchronisers
   // ****************************************************
   logic sda_meta, sda_sync;

   always_ff @(posedge clk) begin
      sda_meta <= bus.sda;
      sda_sync <= sda_meta;
   end

   // ****************************************************
   // sequencer state
   // ****************************************************
   isq_hst_e st_r, st_nxt;
   logic [HOST_CNT_W-1:0] cnt_r, cnt_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [BYTE_W-1:0] shf_r, shf_nxt;
   logic nvm_r, nvm_nxt;
   logic rst_n_r, rst_n_nxt;
   logic scl_low_r, scl_low_nxt;
   logic sda_low_r, sda_low_nxt;
   logic done_r, done_nxt;
   logic ack_r, ack_nxt;
   logic half_end, sda_slot;

   // half period never shorter than the fastest legal clock
   assign half_end = (cnt_r == last_of(HOST_SCL_HALF_CYC)); // see [R09]
   assign sda_slot = (cnt_r == HOST_CNT_W'(HOST_SDA_DELAY_CYC));

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r + 1'b1;
      bit_nxt = bit_r;
      shf_nxt = shf_r;
      nvm_nxt = nvm_r;
      rst_n_nxt = rst_n_r;
      scl_low_nxt = scl_low_r;
      sda_low_nxt = sda_low_r;
      done_nxt = 1'b0;
      ack_nxt = ack_r;
      case (st_r)
         H_RST_LOW: begin
            rst_n_nxt = 1'b0;
            if (cnt_r == last_of(HOLD_CYC)) begin // see [R04] [R05] [R06]
               rst_n_nxt = 1'b1;
               nvm_nxt = nvm_pending;
               cnt_nxt = '0;
               st_nxt = H_WAIT;
            end
         end
         H_WAIT: begin
            if (warm_rst_req) begin
               rst_n_nxt = 1'b0;
               cnt_nxt = '0;
               st_nxt = H_RST_LOW;
            end else if (cnt_r == (nvm_r ? last_of(STARTUP_NVM_CYC) :
                                  last_of(STARTUP_CYC))) begin // see [R02] [R07] [R08]
               cnt_nxt = '0;
               st_nxt = H_IDLE;
            end
         end
         H_IDLE: begin
            cnt_nxt = '0;
            // lines already released here, so reset may drop
            if (warm_rst_req) begin // see [R03]
               rst_n_nxt = 1'b0;
               st_nxt = H_RST_LOW;
            end else if (xfer_req) begin
               shf_nxt = xfer_byte;
               bit_nxt = BIT_FIRST;
               sda_low_nxt = 1'b1;
               st_nxt = H_START;
            end
         end
         H_START: begin
            if (half_end) begin
               scl_low_nxt = 1'b1;
               cnt_nxt = '0;
               st_nxt = H_BIT_LOW;
            end
         end
         H_BIT_LOW: begin
            // data moves only well after the clock fell
            if (sda_slot) begin
               sda_low_nxt = (bit_r == BIT_ACK) ? 1'b0 : !shf_r[BYTE_W-1];
            end
            if (half_end) begin
               scl_low_nxt = 1'b0;
               cnt_nxt = '0;
               st_nxt = H_BIT_HIGH;
            end
         end
         H_BIT_HIGH: begin
            if (half_end) begin
               scl_low_nxt = 1'b1;
               cnt_nxt = '0;
               if (bit_r == BIT_ACK) begin
                  ack_nxt = !sda_sync;
                  st_nxt = H_STOP_LOW;
               end else begin
                  shf_nxt = {shf_r[BYTE_W-2:0], 1'b0};
                  bit_nxt = bit_r + 1'b1;
                  st_nxt = H_BIT_LOW;
               end
            end
         end
         H_STOP_LOW: begin
            if (sda_slot) begin
               sda_low_nxt = 1'b1;
            end
            if (half_end) begin
               scl_low_nxt = 1'b0;
               cnt_nxt = '0;
               st_nxt = H_STOP_HIGH;
            end
         end
         H_STOP_HIGH: begin
            if (half_end) begin
               sda_low_nxt = 1'b0;
               cnt_nxt = '0;
               st_nxt = H_FREE;
            end
         end
         H_FREE: begin
            if (half_end) begin
               done_nxt = 1'b1;
               cnt_nxt = '0;
               st_nxt = H_IDLE;
            end
         end
         default: begin
            st_nxt = H_RST_LOW;
            cnt_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= H_RST_LOW;
         cnt_r <= '0;
         bit_r <= BIT_FIRST;
         shf_r <= '0;
         nvm_r <= 1'b0;
         rst_n_r <= 1'b0;
         // both lines released while the part powers up
         scl_low_r <= 1'b0; // see [R01]
         sda_low_r <= 1'b0; // see [R01]
         done_r <= 1'b0;
         ack_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         bit_r <= bit_nxt;
         shf_r <= shf_nxt;
         nvm_r <= nvm_nxt;
         rst_n_r <= rst_n_nxt;
         scl_low_r <= scl_low_nxt;
         sda_low_r <= sda_low_nxt;
         done_r <= done_nxt;
         ack_r <= ack_nxt;
      end
   end

   // ****************************************************
   // outputs
   // ****************************************************
   assign bus.rst_n = rst_n_r;
   assign bus.host_scl_o = 1'b0;
   assign bus.host_scl_oe_n = !scl_low_r;
   assign bus.host_sda_o = 1'b0;
   assign bus.host_sda_oe_n = !sda_low_r;
   assign ready = (st_r == H_IDLE);
   assign done = done_r;
   assign ack_seen = ack_r;
endmodule

// [tb/isq_checker.sv]
`timescale 1ns/100ps
module isq_checker #(
   parameter int RST_LOW_MIN_CYC = 100,
   parameter int RST_LOW_MAX_CYC = 25000,
   parameter int STARTUP_CYC = 200,
   parameter int DEV_STARTUP_CYC = 400
) (
   // clocks and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic link_clk,
   // link signals
   input wire logic rst_n,
   input wire logic host_scl_o,
   input wire logic host_scl_oe_n,
   input wire logic host_sda_o,
   input wire logic host_sda_oe_n,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe_n,
   input wire logic scl,
   input wire logic sda
);
   logic [15:0] low_cnt_r, low_cnt_nxt, up_cnt_r, up_cnt_nxt, dev_cnt_r, dev_cnt_nxt;

   // ****************************************************
   // time counters
   // ****************************************************
   // cleared in srst so the power-up low span starts from a known count
   always_comb begin
      low_cnt_nxt = (srst || rst_n) ? 16'h0000 : low_cnt_r + 16'h0001;
      up_cnt_nxt = !rst_n ? 16'h0000 : (up_cnt_r < STARTUP_CYC) ? up_cnt_r + 16'h0001 : up_cnt_r;
   end
   always_ff @(posedge clk) begin
      low_cnt_r <= low_cnt_nxt;
      up_cnt_r <= up_cnt_nxt;
   end
   always_comb begin
      dev_cnt_nxt = !rst_n ? 16'h0000 :
                    (dev_cnt_r < DEV_STARTUP_CYC) ? dev_cnt_r + 16'h0001 : dev_cnt_r;
   end
   always_ff @(posedge link_clk) begin
      dev_cnt_r <= dev_cnt_nxt;
   end

   // ****************************************************
   // assertions
   // ****************************************************
   sequence scl_low_seq;
      !scl [*5];
   endsequence
   sequence scl_high_seq;
      scl [*5];
   endsequence

   lines_idle_a: assert property (@(posedge clk) disable iff (srst)
      !rst_n |-> scl && sda && host_scl_oe_n && host_sda_oe_n) else $error("bus busy in reset");
   rst_min_a: assert property (@(posedge clk) disable iff (srst)
      $rose(rst_n) |-> low_cnt_r >= RST_LOW_MIN_CYC) else $error("reset pulse too short");
   rst_max_a: assert property (@(posedge clk) disable iff (srst)
      !rst_n |-> low_cnt_r < RST_LOW_MAX_CYC) else $error("reset pulse too long");
   early_bus_a: assert property (@(posedge clk) disable iff (srst)
      (!scl || !sda) |-> up_cnt_r >= STARTUP_CYC) else $error("bus used before startup");
   scl_low_a: assert property (@(posedge clk) disable iff (srst)
      $fell(scl) |-> scl_low_seq) else $error("scl low phase short");
   scl_high_a: assert property (@(posedge clk) disable iff (srst)
      $rose(scl) |-> scl_high_seq) else $error("scl high phase short");
   dev_quiet_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      !dev_sda_oe_n |-> dev_cnt_r >= DEV_STARTUP_CYC) else $error("device on bus early");
   ack_edge_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      $changed(dev_sda_oe_n) |-> !scl) else $error("ack moved while scl high");
   pins_low_a: assert property (@(posedge clk) disable iff (srst)
      !host_scl_o && !host_sda_o && !dev_sda_o) else $error("open-drain level not low");
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
   import isq_pkg::*;
   localparam int H_START = 200;
   localparam int H_NVM = 300;
   localparam int D_START = 400;
   localparam int D_NVM = 600;
   logic clk, link_clk, srst, warm_rst_req, nvm_pending, xfer_req, nvm_req;
   logic h_ready, h_done, ack_seen, d_ready, rx_valid;
   logic [BYTE_W-1:0] xfer_byte, rx_byte, rx_last;
   logic [BYTE_W-1:0] pats [4] = '{8'hA5, 8'h00, 8'hFF, 8'h3C};
   int n_errors, check_count, rx_cnt;

   isq_link_if link();
   isq_host #(.STARTUP_CYC(H_START), .STARTUP_NVM_CYC(H_NVM)) isq_host_inst (
      .clk(clk), .srst(srst), .bus(link), .warm_rst_req(warm_rst_req),
      .nvm_pending(nvm_pending), .xfer_req(xfer_req), .xfer_byte(xfer_byte),
      .ready(h_ready), .done(h_done), .ack_seen(ack_seen));
   isq_dev #(.STARTUP_CYC(D_START), .STARTUP_NVM_CYC(D_NVM)) isq_dev_inst (
      .link_clk(link_clk), .bus(link), .nvm_req(nvm_req), .ready(d_ready),
      .rx_byte(rx_byte), .rx_valid(rx_valid));
   isq_checker #(.RST_LOW_MIN_CYC(HOST_RST_LOW_MIN_CYC), .RST_LOW_MAX_CYC(HOST_RST_LOW_MAX_CYC),
      .STARTUP_CYC(H_START), .DEV_STARTUP_CYC(D_START)) isq_checker_inst (
      .clk(clk), .srst(srst), .link_clk(link_clk), .rst_n(link.rst_n),
      .host_scl_o(link.host_scl_o), .host_scl_oe_n(link.host_scl_oe_n),
      .host_sda_o(link.host_sda_o), .host_sda_oe_n(link.host_sda_oe_n),
      .dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n),
      .scl(link.scl), .sda(link.sda));

   // ****************************************************
   // clocks and receive capture
   // ****************************************************
   initial clk = 1'h0;
   always #50 clk = ~clk;
   initial begin
      link_clk = 1'h0;
      #1.3;
      forever #3 link_clk = ~link_clk;
   end
   always @(posedge link_clk) begin
      if (rx_valid === 1'h1) begin
         rx_last <= rx_byte;
         rx_cnt <= rx_cnt + 1;
      end
   end

   // ****************************************************
   // compare and access tasks
   // ****************************************************
   task check_bit(input logic got, input logic exp, input string msg);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %b exp %b", $time, msg, got, exp);
      end
   endtask
   task check_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task check_num(input int got, input int exp, input string msg);
      check_count++;
      if (got != exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %0d exp %0d", $time, msg, got, exp);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // low span, then startup span with a refused early request
   task measure(input int exp_low, input int exp_up, input logic nonvolatile_store);
      int n;
      int m;
      n = 0;
      m = 0;
      while (link.rst_n !== 1'h1 && n < 30000) begin
         n++;
         @(negedge clk);
      end
      if (exp_low > 0) check_num(n, exp_low, "reset low cycles");
      check_bit(d_ready, 1'h0, "device ready in reset");
      fork
         while (h_ready !== 1'h1 && m < 1000) begin
            m++;
            @(negedge clk);
         end
         begin
            repeat (500) @(posedge link_clk);
            #1 check_bit(d_ready, ~nonvolatile_store, "device startup span");
         end
         begin
            @(negedge clk) xfer_req = 1'h1;
            @(negedge clk) xfer_req = 1'h0;
            repeat (2) @(negedge clk);
            check_bit(link.sda, 1'h1, "early request refused");
         end
      join
      check_num(m, exp_up, "host startup cycles");
      check_bit(d_ready, 1'h1, "device ready at host ready");
   endtask
   task warm(input logic nonvolatile_store, input int exp_up);
      nvm_pending = nonvolatile_store;
      nvm_req = nonvolatile_store;
      warm_rst_req = 1'h1;
      @(negedge clk) warm_rst_req = 1'h0;
      check_bit(link.rst_n, 1'h0, "reset pin low");
      check_bit(link.scl & link.sda, 1'h1, "lines high in reset");
      measure(HOST_RST_LOW_MIN_CYC, exp_up, nonvolatile_store);
      nvm_pending = 1'h0;
      nvm_req = 1'h0;
   endtask
   task send(input logic [7:0] b, input logic bump);
      int n;
      int rx0;
      n = 0;
      rx0 = rx_cnt;
      xfer_byte = b;
      xfer_req = 1'h1;
      @(negedge clk) xfer_req = 1'h0;
      while (h_done !== 1'h1 && n < 200) begin
         @(negedge clk);
         n++;
         warm_rst_req = (bump && n == 20) ? 1'h1 : 1'h0;
      end
      check_num(n, 110, "transfer cycles");
      check_bit(ack_seen, 1'h1, "device ack");
      check_bit(link.rst_n, 1'h1, "warm request ignored mid transfer");
      check_byte(rx_last, b, "received byte");
      check_num(rx_cnt, rx0 + 1, "bytes received");
      @(negedge clk);
      check_bit(h_ready, 1'h1, "ready after transfer");
   endtask

   // ****************************************************
   // main sequence and watchdog
   // ****************************************************
   initial begin
      srst = 1'h1;
      warm_rst_req = 1'h0;
      nvm_pending = 1'h0;
      nvm_req = 1'h0;
      xfer_req = 1'h0;
      xfer_byte = 8'h00;
      n_errors = 0;
      check_count = 0;
      rx_cnt = 0;
      repeat (2) @(negedge clk);
      srst = 1'h0;
      check_bit(link.scl & link.sda, 1'h1, "lines high at power-up");
      measure(0, H_START, 1'h0);
      for (int i = 0; i < 4; i++) send(pats[i], i == 2);
      warm(1'h0, H_START);
      warm(1'h1, H_NVM);
      send(8'h5A, 1'h0);
      conclude();
   end
   initial begin
      #(20000 * 100);
      n_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      conclude();
   end
endmodule
